// ---- hw/pmbus_status_pkg.sv ----
// Package for the management-bus status and fault-clear block.
// Assumes one core clock; all bus pins are sampled, never used as clocks.
package pmbus_status_pkg;

    // Command codes selecting each status item on the management bus
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CMD_EXT_TEMP = 8'h7d;
    localparam logic [7:0] CMD_COMM_LOGIC = 8'h7e;
    localparam logic [7:0] CMD_VENDOR_FAULT = 8'h80;
    localparam logic [7:0] CMD_PIN_STATE = 8'he5;
    localparam logic [7:0] CMD_COMMON = 8'hef;
    localparam logic [7:0] CMD_ECC_INFO = 8'hb6;

    // Supported (clearable) bits of each sticky byte; the rest read zero
    localparam logic [7:0] EXT_TEMP_MASK = 8'hc0;
    localparam logic [7:0] COMM_LOGIC_MASK = 8'hfb;
    localparam logic [7:0] VENDOR_FAULT_MASK = 8'hfb;

    // Communication byte bit positions raised by the serial engine itself
    localparam int COMM_BIT_BAD_CMD = 7;
    localparam int COMM_BIT_BAD_DATA = 6;

    // Field positions in the read-only words
    localparam int ECC_CLEAN_BIT = 5;
    localparam int SUMMARY_BIT_IN_STATUS_WORD = 12;

    // Sticky status reset value and serial framing constants
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [1:0] LAST_BYTE_IDX = 2'h2;

    // Serial engine states, Gray coded along address, command, data
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_CMD = 3'b011,
        ST_WDATA = 3'b010,
        ST_RDATA = 3'b110
    } bus_state_e;

    // One byte per clearable status item
    typedef struct packed
    {
        logic [7:0] ext_temp;
        logic [7:0] comm_logic;
        logic [7:0] vendor;
    } status_set_s;

    // Same-domain inputs that build the read-only words
    typedef struct packed
    {
        logic [1:0] stages_ready;
        logic temp_result_suspect;
        logic phase_clk_off;
        logic [1:0] power_good;
        logic [1:0] enable_pull_low;
        logic [1:0] error_pull_low;
    } pin_info_s;

    typedef struct packed
    {
        logic busy;
        logic calc_pending;
        logic in_transition;
        logic nvm_ready;
        logic timebase_timeout;
        logic ecc_corrected;
    } common_info_s;

endpackage

// ---- hw/pmbus_status.sv ----
// Status bytes, read-only info words and global fault clear behind a
// two-wire management bus slave (read byte/word, write byte, send byte).
// Assumes fault conditions arrive as same-domain levels; scl, sda and the
// enable/error pin levels come from pins and are synchronised here.
`timescale 1ns/1ps

// Behaviour
// - Ext temp byte: fault bit7, warn bit6, rest zero
// - Ext temp bits drive alert, one-write clears bit
// - Comm byte: bits 7..3,1,0 flagged; bit2 zero
// - Comm bits drive alert; one-write clears that bit
// - Vendor byte: 7..3,1,0 flagged; bit2 zero
// - Vendor bits set summary, alert; one-write clears
// - Pin word high byte: ready, suspect, clock, good
// - Pin word low byte: pull-lows, levels; read-only
// - Common byte: alert, busy, calc, transition, nvm, timeout
// - Info word bit5: one means no correction
// - Clear-faults clears all bytes, releases alert together
// - Clear-faults never restarts a latched-off channel
// - Persisting fault re-sets bit, alert unless masked
// - Status word bit12 summarises vendor byte
module pmbus_status #(
    parameter logic [6:0] DEV_ADDR = 7'h40
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe,
    output logic o_alert,
    output logic o_alert_oe,
    input wire pmbus_status_pkg::status_set_s i_fault_cond,
    input wire pmbus_status_pkg::status_set_s i_alert_mask,
    input wire pmbus_status_pkg::pin_info_s i_pin_info,
    input wire logic [1:0] i_enable_pin_lvl,
    input wire logic [1:0] i_error_pin_lvl,
    input wire pmbus_status_pkg::common_info_s i_common_info,
    output logic o_vendor_summary_bit,
    output logic [15:0] o_summary_word_bits,
    output logic o_clear_faults
);
    import pmbus_status_pkg::*;

    // Two-flop synchronisers for every pin input
    logic [1:0] scl_sync_q;
    logic [1:0] sda_sync_q;
    logic [1:0] en_lvl_s1_q;
    logic [1:0] en_lvl_q;
    logic [1:0] err_lvl_s1_q;
    logic [1:0] err_lvl_q;
    logic scl_prev_q; // Last synced scl, for edge finding
    logic sda_prev_q; // Last synced sda, for start/stop

    // Serial engine state
    bus_state_e state_q;
    logic [3:0] bit_cnt_q; // Bits taken in the current byte
    logic [1:0] byte_cnt_q; // Data bytes handled, saturating
    logic ack_phase_q; // Inside the ninth clock
    logic master_nack_q; // Host refused our last byte
    logic [7:0] shift_q; // In and out shift register
    logic [7:0] cmd_q; // Command code of this transaction
    logic sda_oe_q; // Pulling sda low

    // One-cycle events from the engine to the status bytes
    logic clr_all_q;
    logic w1c_q;
    logic [7:0] w1c_data_q;
    logic bad_cmd_q;
    logic bad_data_q;

    // Sticky status and derived words
    status_set_s sticky_q;
    status_set_s set_vec;
    status_set_s clr_vec;
    logic [15:0] pin_word;
    logic [7:0] common_byte;
    logic [15:0] info_word;
    logic [15:0] rd_word;
    logic [7:0] rd_byte;
    logic alert_any;

    wire scl_rise = scl_sync_q[1] & ~scl_prev_q;
    wire scl_fall = ~scl_sync_q[1] & scl_prev_q;
    wire bus_start = scl_sync_q[1] & scl_prev_q & sda_prev_q & ~sda_sync_q[1];
    wire bus_stop = scl_sync_q[1] & scl_prev_q & ~sda_prev_q & sda_sync_q[1];

    // Known command codes; anything else is flagged as invalid
    function automatic logic cmd_known(input logic [7:0] c);
        cmd_known = (c == CMD_CLEAR_FAULTS) || (c == CMD_EXT_TEMP) ||
            (c == CMD_COMM_LOGIC) || (c == CMD_VENDOR_FAULT) ||
            (c == CMD_PIN_STATE) || (c == CMD_COMMON) || (c == CMD_ECC_INFO);
    endfunction

    // Only the three sticky bytes accept a data write
    function automatic logic cmd_w1c(input logic [7:0] c);
        cmd_w1c = (c == CMD_EXT_TEMP) || (c == CMD_COMM_LOGIC) ||
            (c == CMD_VENDOR_FAULT);
    endfunction

    // Pin synchronisers; first stages feed only the second stages
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
            en_lvl_s1_q <= 2'h0;
            en_lvl_q <= 2'h0;
            err_lvl_s1_q <= 2'h0;
            err_lvl_q <= 2'h0;
        end
        else
        begin
            scl_sync_q <= {scl_sync_q[0], i_scl};
            sda_sync_q <= {sda_sync_q[0], i_sda};
            scl_prev_q <= scl_sync_q[1];
            sda_prev_q <= sda_sync_q[1];
            en_lvl_s1_q <= i_enable_pin_lvl;
            en_lvl_q <= en_lvl_s1_q;
            err_lvl_s1_q <= i_error_pin_lvl;
            err_lvl_q <= err_lvl_s1_q;
        end
    end

    // Serial engine: byte framing, ack, command decode, read shifting
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_q <= ST_IDLE;
            bit_cnt_q <= 4'h0;
            byte_cnt_q <= 2'h0;
            ack_phase_q <= 1'b0;
            master_nack_q <= 1'b0;
            shift_q <= 8'h00;
            cmd_q <= 8'h00;
            sda_oe_q <= 1'b0;
            clr_all_q <= 1'b0;
            w1c_q <= 1'b0;
            w1c_data_q <= 8'h00;
            bad_cmd_q <= 1'b0;
            bad_data_q <= 1'b0;
        end
        else
        begin
            clr_all_q <= 1'b0;
            w1c_q <= 1'b0;
            bad_cmd_q <= 1'b0;
            bad_data_q <= 1'b0;
            if (bus_start)
            begin
                // Start or repeated start; command code is kept for reads
                state_q <= ST_ADDR;
                bit_cnt_q <= 4'h0;
                ack_phase_q <= 1'b0;
                sda_oe_q <= 1'b0;
            end
            else if (bus_stop)
            begin
                // Command byte alone, then stop: the send-byte clear
                if (state_q == ST_WDATA && byte_cnt_q == 2'h0 &&
                    cmd_q == CMD_CLEAR_FAULTS)
                begin
                    clr_all_q <= 1'b1;
                end
                state_q <= ST_IDLE;
                ack_phase_q <= 1'b0;
                sda_oe_q <= 1'b0;
            end
            else if (scl_rise && state_q != ST_IDLE)
            begin
                if (ack_phase_q)
                begin
                    master_nack_q <= sda_sync_q[1]; // Host ack after a read byte
                end
                else
                begin
                    if (state_q != ST_RDATA)
                    begin
                        shift_q <= {shift_q[6:0], sda_sync_q[1]};
                    end
                    bit_cnt_q <= bit_cnt_q + 4'h1;
                end
            end
            else if (scl_fall && state_q != ST_IDLE)
            begin
                if (ack_phase_q)
                begin
                    // End of ninth clock: release, or present next read byte
                    ack_phase_q <= 1'b0;
                    sda_oe_q <= 1'b0;
                    if (state_q == ST_RDATA)
                    begin
                        if (master_nack_q)
                        begin
                            state_q <= ST_IDLE; // Host ends the read
                        end
                        else
                        begin
                            shift_q <= rd_byte;
                            sda_oe_q <= ~rd_byte[7];
                            if (byte_cnt_q != LAST_BYTE_IDX)
                            begin
                                byte_cnt_q <= byte_cnt_q + 2'h1;
                            end
                        end
                    end
                end
                else if (bit_cnt_q == BITS_PER_BYTE)
                begin
                    bit_cnt_q <= 4'h0;
                    ack_phase_q <= 1'b1;
                    unique case (state_q)
                        ST_IDLE:
                        begin
                            ack_phase_q <= 1'b0;
                        end
                        ST_ADDR:
                        begin
                            if (shift_q[7:1] == DEV_ADDR)
                            begin
                                sda_oe_q <= 1'b1;
                                master_nack_q <= 1'b0;
                                byte_cnt_q <= 2'h0;
                                state_q <= shift_q[0] ? ST_RDATA : ST_CMD;
                                // The clear command has nothing to read
                                if (shift_q[0] && cmd_q == CMD_CLEAR_FAULTS)
                                begin
                                    bad_cmd_q <= 1'b1;
                                end
                            end
                            else
                            begin
                                // Not ours: stay off the bus until next start
                                state_q <= ST_IDLE;
                                ack_phase_q <= 1'b0;
                            end
                        end
                        ST_CMD:
                        begin
                            // Acked even when unknown, then flagged
                            cmd_q <= shift_q;
                            sda_oe_q <= 1'b1;
                            byte_cnt_q <= 2'h0;
                            state_q <= ST_WDATA;
                            bad_cmd_q <= ~cmd_known(shift_q);
                        end
                        ST_WDATA:
                        begin
                            sda_oe_q <= 1'b1;
                            if (byte_cnt_q != LAST_BYTE_IDX)
                            begin
                                byte_cnt_q <= byte_cnt_q + 2'h1;
                            end
                            if (cmd_w1c(cmd_q) && byte_cnt_q == 2'h0)
                            begin
                                w1c_q <= 1'b1;
                                w1c_data_q <= shift_q;
                            end
                            else
                            begin
                                // Writes to read-only words or extra bytes
                                bad_data_q <= 1'b1;
                            end
                        end
                        ST_RDATA:
                        begin
                            sda_oe_q <= 1'b0; // Hand sda to the host for ack
                        end
                    endcase
                end
                else if (state_q == ST_RDATA)
                begin
                    // Next bit of a read byte, MSB first
                    shift_q <= {shift_q[6:0], 1'b0};
                    sda_oe_q <= ~shift_q[6];
                end
            end
        end
    end

    // Hardware set sources; engine adds its own comm flags
    always_comb
    begin
        set_vec = i_fault_cond;
        set_vec.comm_logic[COMM_BIT_BAD_CMD] = i_fault_cond.comm_logic[COMM_BIT_BAD_CMD] |
            bad_cmd_q;
        set_vec.comm_logic[COMM_BIT_BAD_DATA] = i_fault_cond.comm_logic[COMM_BIT_BAD_DATA] |
            bad_data_q;
        set_vec.ext_temp = set_vec.ext_temp & EXT_TEMP_MASK;
        set_vec.comm_logic = set_vec.comm_logic & COMM_LOGIC_MASK;
        set_vec.vendor = set_vec.vendor & VENDOR_FAULT_MASK;
    end

    // Clear sources: one-writes to the addressed byte, or all at once
    always_comb
    begin
        clr_vec = '{default: {8{clr_all_q}}};
        if (w1c_q && cmd_q == CMD_EXT_TEMP)
        begin
            clr_vec.ext_temp = clr_vec.ext_temp | w1c_data_q;
        end
        if (w1c_q && cmd_q == CMD_COMM_LOGIC)
        begin
            clr_vec.comm_logic = clr_vec.comm_logic | w1c_data_q;
        end
        if (w1c_q && cmd_q == CMD_VENDOR_FAULT)
        begin
            clr_vec.vendor = clr_vec.vendor | w1c_data_q;
        end
    end

    // Sticky bits; a set in the clear cycle wins, so a lasting fault
    // comes straight back after any clear
    for (genvar b = 0; b < $bits(status_set_s); b++)
    begin : g_sticky
        always_ff @(posedge i_core_clk or negedge i_rst_n)
        begin
            if (!i_rst_n)
            begin
                sticky_q[b] <= 1'b0;
            end
            else
            begin
                sticky_q[b] <= set_vec[b] | (sticky_q[b] & ~clr_vec[b]);
            end
        end
    end

    // Alert pulls low while any unmasked sticky bit stands
    assign alert_any = |(sticky_q & ~i_alert_mask);

    // Read-only words built from live state
    assign pin_word = {i_pin_info.stages_ready, 2'b00, i_pin_info.temp_result_suspect,
        i_pin_info.phase_clk_off, i_pin_info.power_good, i_pin_info.enable_pull_low,
        en_lvl_q, i_pin_info.error_pull_low, err_lvl_q};
    assign common_byte = {~alert_any, ~i_common_info.busy, ~i_common_info.calc_pending,
        ~i_common_info.in_transition, i_common_info.nvm_ready, 1'b0,
        i_common_info.timebase_timeout, 1'b0};

    // Info word: only the correction flag, reserved bits zero
    always_comb
    begin
        info_word = 16'h0000;
        info_word[ECC_CLEAN_BIT] = ~i_common_info.ecc_corrected;
    end

    // Read mux: low byte first, then high; past the end reads zero
    always_comb
    begin
        unique case (cmd_q)
            CMD_EXT_TEMP: rd_word = {8'h00, sticky_q.ext_temp};
            CMD_COMM_LOGIC: rd_word = {8'h00, sticky_q.comm_logic};
            CMD_VENDOR_FAULT: rd_word = {8'h00, sticky_q.vendor};
            CMD_PIN_STATE: rd_word = pin_word;
            CMD_COMMON: rd_word = {8'h00, common_byte};
            CMD_ECC_INFO: rd_word = info_word;
            default: rd_word = 16'h0000; // Unknown or clear command
        endcase
        rd_byte = (byte_cnt_q == 2'h0) ? rd_word[7:0] :
            (byte_cnt_q == 2'h1) ? rd_word[15:8] : 8'h00;
    end

    // Summary bit into the status word held elsewhere
    always_comb
    begin
        o_summary_word_bits = 16'h0000;
        o_summary_word_bits[SUMMARY_BIT_IN_STATUS_WORD] = |sticky_q.vendor;
    end

    assign o_vendor_summary_bit = |sticky_q.vendor;
    // Only a notice to channel logic; latched-off channels stay off
    assign o_clear_faults = clr_all_q;
    assign o_sda = 1'b0;
    assign o_sda_oe = sda_oe_q;
    assign o_alert = 1'b0;
    assign o_alert_oe = alert_any;

endmodule

// ---- testbench/pmbus_status_monitor.sv ----
// Port-level checks on the status and fault-clear block.
// Assumes one core clock domain with an active-low asynchronous reset.
`timescale 1ns/1ps
module pmbus_status_monitor (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_scl,
    input wire pmbus_status_pkg::status_set_s i_fault_cond,
    input wire pmbus_status_pkg::status_set_s i_alert_mask,
    input wire logic o_sda,
    input wire logic o_alert,
    input wire logic o_alert_oe,
    input wire logic o_vendor_summary_bit,
    input wire logic [15:0] o_summary_word_bits,
    input wire logic o_clear_faults
);
    import pmbus_status_pkg::*;
    // Supported bits of the three sticky bytes
    localparam logic [23:0] SUP = {EXT_TEMP_MASK, COMM_LOGIC_MASK, VENDOR_FAULT_MASK};
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    a_fault_sets_alert: assert property (|(i_fault_cond & SUP & ~i_alert_mask) ##1
        $stable(i_alert_mask) |-> o_alert_oe) else $error("alert missing after fault");
    a_vendor_sets_summary: assert property (|(i_fault_cond.vendor & VENDOR_FAULT_MASK)
        |=> o_vendor_summary_bit) else $error("vendor summary missing");
    a_summary_rise_cause: assert property ($rose(o_vendor_summary_bit)
        |-> $past(|(i_fault_cond.vendor & VENDOR_FAULT_MASK))) else $error("summary rose alone");
    a_status_word_bit: assert property (o_summary_word_bits
        == {3'h0, o_vendor_summary_bit, 12'h000}) else $error("status word bits wrong");
    a_clear_releases_alert: assert property (o_clear_faults && i_fault_cond == '0
        |=> !o_alert_oe && !o_vendor_summary_bit) else $error("clear left faults set");
    a_persist_reasserts: assert property (o_clear_faults &&
        |(i_fault_cond.ext_temp & EXT_TEMP_MASK & ~i_alert_mask.ext_temp) ##1
        $stable(i_alert_mask) |-> o_alert_oe) else $error("persisting fault lost alert");
    a_mask_quiets_alert: assert property (&i_alert_mask |-> !o_alert_oe)
        else $error("masked alert driven");
    a_clear_single_pulse: assert property (o_clear_faults |=> !o_clear_faults [*8])
        else $error("clear pulse repeated");
    a_clear_after_stop: assert property (o_clear_faults |-> i_scl && $past(i_scl, 2))
        else $error("clear outside stop");
    a_open_drain_low: assert property (!o_sda && !o_alert)
        else $error("open-drain value not low");
endmodule

bind pmbus_status pmbus_status_monitor u_pmbus_status_monitor (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_scl(i_scl),
    .i_fault_cond(i_fault_cond),
    .i_alert_mask(i_alert_mask),
    .o_sda(o_sda),
    .o_alert(o_alert),
    .o_alert_oe(o_alert_oe),
    .o_vendor_summary_bit(o_vendor_summary_bit),
    .o_summary_word_bits(o_summary_word_bits),
    .o_clear_faults(o_clear_faults)
);

// ---- testbench/pmbus_host.sv ----
// Behavioural management-bus host: drives scl and a wired-AND sda.
// Assumes the bench core clock; all pin moves land on its falling edge.
`timescale 1ns/1ps
module pmbus_host (
    input wire logic i_clk,
    input wire logic i_dev_sda_oe,
    output logic o_scl,
    output logic o_sda
);
    logic pull_q; // Host pulling sda low
    // Pull-up wins unless either party pulls low
    assign o_sda = !pull_q && !i_dev_sda_oe;
    initial
    begin
        o_scl = 1'b1;
        pull_q = 1'b0;
    end
    // Half of a 200 ns scl period
    task automatic half();
        repeat (4) @(negedge i_clk);
    endtask
    // One bit; data moves a cycle after scl falls
    task automatic bit_io(input logic b, output logic r);
        @(negedge i_clk);
        pull_q = !b;
        repeat (3) @(negedge i_clk);
        o_scl = 1'b1;
        half();
        r = o_sda;
        o_scl = 1'b0;
    endtask
    // Start or repeated start
    task automatic start();
        @(negedge i_clk);
        pull_q = 1'b0;
        half();
        o_scl = 1'b1;
        half();
        pull_q = 1'b1;
        half();
        o_scl = 1'b0;
    endtask
    task automatic stop();
        @(negedge i_clk);
        pull_q = 1'b1;
        half();
        o_scl = 1'b1;
        half();
        pull_q = 1'b0;
        half();
    endtask
    // Eight bits MSB first, then the ninth (ack) bit
    task automatic byte_io(input logic [7:0] d, input logic last, output logic [7:0] q,
        output logic ack_n);
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(d[i], q[i]);
        end
        bit_io(last, ack_n);
    endtask
    // Write with one data byte when n is above zero; zero is a send-byte
    task automatic write(input logic [6:0] addr, input logic [7:0] cmd, input int n,
        input logic [7:0] d, output logic nak);
        logic [7:0] q;
        logic a0, a1, a2;
        start();
        byte_io({addr, 1'b0}, 1'b1, q, a0);
        byte_io(cmd, 1'b1, q, a1);
        a2 = 1'b0;
        if (n > 0)
        begin
            byte_io(d, 1'b1, q, a2);
        end
        stop();
        nak = a0 | a1 | a2;
    endtask
    // Read one or two bytes, low byte first, last one refused
    task automatic read(input logic [6:0] addr, input logic [7:0] cmd, input int n,
        output logic [15:0] d);
        logic [7:0] q;
        logic a;
        start();
        byte_io({addr, 1'b0}, 1'b1, q, a);
        byte_io(cmd, 1'b1, q, a);
        start();
        byte_io({addr, 1'b1}, 1'b1, q, a);
        byte_io(8'hff, n == 1, q, a);
        d = {8'h00, q};
        if (n > 1)
        begin
            byte_io(8'hff, 1'b1, q, a);
            d[15:8] = q;
        end
        stop();
    endtask
endmodule

// ---- testbench/pmbus_status_test.sv ----
// Self-checking bench for the status and fault-clear block.
// Assumes the host model and the bound port checker.
`timescale 1ns/1ps
module pmbus_status_test;
    import pmbus_status_pkg::*;
    localparam logic [6:0] ADDR = 7'h40; // Device address
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    status_set_s cond, mask;
    pin_info_s pin;
    common_info_s com;
    logic [1:0] en_lvl, err_lvl;
    logic scl, sda, sda_o, sda_oe, alert, alert_oe, vsum, clr, nak;
    logic [15:0] sword, rd;
    logic [7:0] exp [3]; // Expected sticky bytes
    logic [31:0] rnd;
    integer failures = 0, check_count = 0, seed = 32'hec76, cycles = 0, clr_seen = 0, c0;

    pmbus_status #(.DEV_ADDR(ADDR)) u_pmbus_status (.i_core_clk(core_clk), .i_rst_n(rst_n),
        .i_scl(scl), .i_sda(sda), .o_sda(sda_o), .o_sda_oe(sda_oe), .o_alert(alert),
        .o_alert_oe(alert_oe), .i_fault_cond(cond), .i_alert_mask(mask), .i_pin_info(pin),
        .i_enable_pin_lvl(en_lvl), .i_error_pin_lvl(err_lvl), .i_common_info(com),
        .o_vendor_summary_bit(vsum), .o_summary_word_bits(sword), .o_clear_faults(clr));
    pmbus_host u_pmbus_host (.i_clk(core_clk), .i_dev_sda_oe(sda_oe), .o_scl(scl), .o_sda(sda));

    initial
    begin
        forever #12.5 core_clk = !core_clk;
    end
    // Cycle ceiling and clear pulse count
    always @(posedge core_clk)
    begin
        cycles++;
        if (clr === 1'b1) clr_seen++;
        if (cycles == 60000)
        begin
            failures++;
            conclude();
        end
    end
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] want);
        check_count++;
        if (seen !== want)
        begin
            failures++;
            $display("unexpected %s expected %h seen %h", name, want, seen);
        end
    endtask
    task automatic conclude();
        if (failures == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    function automatic logic [7:0] sup(input int i);
        return i == 0 ? EXT_TEMP_MASK : (i == 1 ? COMM_LOGIC_MASK : VENDOR_FAULT_MASK);
    endfunction
    function automatic logic [7:0] cmd_of(input int i);
        return i == 0 ? CMD_EXT_TEMP : (i == 1 ? CMD_COMM_LOGIC : CMD_VENDOR_FAULT);
    endfunction
    function automatic logic [15:0] pin_exp(input pin_info_s p, input logic [1:0] e,
        input logic [1:0] f);
        return {p.stages_ready, 2'b00, p.temp_result_suspect, p.phase_clk_off, p.power_good,
            p.enable_pull_low, e, p.error_pull_low, f};
    endfunction
    function automatic logic [15:0] com_exp(input common_info_s c);
        return {8'h00, 1'b1, !c.busy, !c.calc_pending, !c.in_transition, c.nvm_ready, 1'b0,
            c.timebase_timeout, 1'b0};
    endfunction
    // Short fault pulse on one byte
    task automatic raise(input int i, input logic [7:0] v);
        @(negedge core_clk);
        cond[8*(2-i) +: 8] = v;
        repeat (2) @(negedge core_clk);
        cond = '0;
    endtask
    task automatic read_all(input string name);
        for (int i = 0; i < 3; i++)
        begin
            u_pmbus_host.read(ADDR, cmd_of(i), 1, rd);
            check(name, rd, {8'h00, exp[i]});
        end
    endtask

    initial
    begin
        {cond, mask, pin, com, en_lvl, err_lvl} = '0;
        repeat (10) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (5) @(negedge core_clk);
        exp = '{default: 8'h00};
        read_all("reset status");
        // All-ones faults in the first round, random faults after, then random one-writes
        for (int r = 0; r < 4; r++)
        begin
            for (int i = 0; i < 3; i++)
            begin
                rnd = (r == 0) ? 32'hffffffff : $random(seed);
                raise(i, rnd[7:0]);
                exp[i] = exp[i] | (rnd[7:0] & sup(i));
                check("alert", alert_oe, |{exp[0], exp[1], exp[2]});
                check("summary", vsum, |exp[2]);
                check("status word", sword, {3'h0, |exp[2], 12'h000});
                rnd = $random(seed);
                u_pmbus_host.write(ADDR, cmd_of(i), 1, rnd[15:8], nak);
                check("write ack", nak, 1'b0);
                exp[i] = exp[i] & ~rnd[15:8];
            end
            read_all("sticky byte");
        end
        // Clear with a persisting, masked fault
        for (int i = 0; i < 3; i++) raise(i, 8'hff);
        @(negedge core_clk);
        mask = '1;
        cond.ext_temp = 8'h80;
        c0 = clr_seen;
        u_pmbus_host.write(ADDR, CMD_CLEAR_FAULTS, 0, 8'h00, nak);
        check("clear pulses", clr_seen - c0, 16'h0001);
        check("masked alert", alert_oe, 1'b0);
        exp = '{8'h80, 8'h00, 8'h00};
        read_all("after clear");
        mask = '0;
        u_pmbus_host.write(ADDR, CMD_CLEAR_FAULTS, 0, 8'h00, nak);
        check("persist alert", alert_oe, 1'b1);
        cond = '0;
        u_pmbus_host.write(ADDR, CMD_EXT_TEMP, 1, 8'h80, nak);
        check("alert released", alert_oe, 1'b0);
        // Read-only words
        for (int r = 0; r < 3; r++)
        begin
            rnd = (r == 0) ? 32'hffffffff : $random(seed);
            {com, pin, en_lvl, err_lvl} = rnd[19:0];
            u_pmbus_host.read(ADDR, CMD_PIN_STATE, 2, rd);
            check("pin word", rd, pin_exp(pin, en_lvl, err_lvl));
            u_pmbus_host.read(ADDR, CMD_COMMON, 1, rd);
            check("common", rd, com_exp(com));
            u_pmbus_host.read(ADDR, CMD_ECC_INFO, 2, rd);
            check("info", rd, {10'h000, !com.ecc_corrected, 5'h00});
        end
        // Invalid commands, data and reads flag the communication byte; a foreign address is only nacked
        u_pmbus_host.write(ADDR, CMD_PIN_STATE, 1, 8'h5a, nak);
        u_pmbus_host.write(ADDR, 8'h55, 1, 8'h00, nak);
        u_pmbus_host.read(ADDR, CMD_CLEAR_FAULTS, 1, rd);
        check("clear read", rd, 16'h0000);
        u_pmbus_host.write(ADDR ^ 7'h01, CMD_COMM_LOGIC, 1, 8'hff, nak);
        check("wrong address", nak, 1'b1);
        u_pmbus_host.read(ADDR, CMD_COMM_LOGIC, 1, rd);
        check("refusals", rd, 16'h00c0);
        u_pmbus_host.write(ADDR, CMD_COMM_LOGIC, 1, 8'h40, nak);
        u_pmbus_host.read(ADDR, CMD_COMM_LOGIC, 1, rd);
        check("single clear", rd, 16'h0080);
        u_pmbus_host.write(ADDR, CMD_CLEAR_FAULTS, 0, 8'h00, nak);
        check("final alert", alert_oe, 1'b0);
        conclude();
    end
endmodule
